// file: mso_map.svh
`ifndef MSO_MAP_SVH
`define MSO_MAP_SVH
// ==========================================
// program space
`define MSO_CODE_ONCHIP_TOP 16'h1FFF
// ==========================================
// internal ram layout
`define MSO_RAM_BANK_TOP 8'h1F
`define MSO_RAM_BIT_BASE 8'h20
`define MSO_RAM_BIT_TOP 8'h2F
`define MSO_RAM_SCRATCH_BASE 8'h30
`define MSO_RAM_SCRATCH_TOP 8'h7F
`define MSO_UPPER_BIT 7
`define MSO_BANK_SHIFT 3
// ==========================================
// special function register addresses
`define MSO_SFR_SP 8'h81
`define MSO_SFR_FLAGS 8'hD0
`define MSO_SFR_ACC 8'hE0
`define MSO_SFR_AUX 8'hF0
`define MSO_FLAGS_BANK_LO 3
`define MSO_FLAGS_BANK_HI 4
// ==========================================
// reset values
`define MSO_SP_RST 8'h07
`define MSO_BYTE_ZERO 8'h00
`define MSO_RD_FILL 8'hFF
// ==========================================
// timing
`define MSO_PHASES_PER_CYCLE 3'h6
`define MSO_PHASE_LAST 3'h5
`define MSO_STROBE_PH_A 3'h1
`define MSO_STROBE_PH_B 3'h4
`define MSO_DATA_STROBE_PH 3'h3
`define MSO_RST_SAMPLES 2'h2
`endif

// file: mso_pkg.sv
package mso_pkg;
  typedef enum logic [1:0] {MSO_OP_READ, MSO_OP_WRITE, MSO_OP_PUSH, MSO_OP_POP} mso_op_e;
  typedef enum logic [1:0] {MSO_MUL_NONE, MSO_MUL_LOAD} mso_mul_e;
  typedef enum logic {MSO_DIRECT, MSO_INDIRECT} mso_mode_e;
  // one internal-memory request from the core
  typedef struct packed {
    logic valid;
    mso_op_e op;
    mso_mode_e mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mso_req_s;
  // one external-memory request
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } mso_xreq_s;
  typedef enum {MSO_X_IDLE, MSO_X_BUSY} mso_xstate_e;
endpackage

// file: mso_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mso_map.svh"
// What this block does
// - program and data memories are separate spaces of up to 64K each.
// - code below 8K comes from chip; higher fetches go external.
// - external code execution pulses the program strobe twice per machine cycle.
// - an external data access drops two consecutive program strobe pulses.
// - program strobe stays inactive for on-chip code fetches.
// - reset high for two machine cycles resets; caller must hold it.
// - port 3 bit 6 strobes data writes, bit 7 strobes data reads.
// - 256 bytes ram; lower 128 reachable direct and indirect.
// - upper 128 ram bytes reachable only indirectly.
// - four banks of eight work registers occupy 00H to 1FH.
// - bank 0 selected after reset until software changes it.
// - reset loads stack pointer with 07H so stack starts at 08H.
// - 20H-2FH byte addressable, and its 128 bits bit addressable.
// - 30H-7FH is general scratch storage.
// - special function registers decode in upper direct range.
// - unoccupied function addresses read arbitrary data, ignore writes.
// - auxiliary register is multiply/divide operand and result, else scratch.
// - stack pointer increments before each pushed byte is stored.
// - fetch select low makes all code fetches 0000H-FFFFH external.
module mso_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // reset pin and fetch select
  input wire logic reset_pin_in,
  input wire logic external_fetch_select_n_in,
  // code fetch
  input wire logic fetch_valid_in,
  input wire logic [15:0] fetch_addr_in,
  // internal memory access
  input wire mso_pkg::mso_req_s mem_req_in,
  input wire logic bit_access_in,
  input wire logic [6:0] bit_addr_in,
  input wire logic bank_work_in,
  input wire logic [2:0] bank_reg_in,
  input wire mso_pkg::mso_mul_e mul_op_in,
  input wire logic [7:0] mul_result_in,
  // external data access
  input wire mso_pkg::mso_xreq_s xdata_req_in,
  // results
  output logic [7:0] mem_rdata_out,
  output logic bit_rdata_out,
  output logic [7:0] stack_pointer_out,
  output logic [1:0] bank_select_out,
  output logic [7:0] multiply_divide_aux_out,
  output logic fetch_external_out,
  output logic [15:0] code_addr_out,
  output logic [15:0] xdata_addr_out,
  output logic machine_cycle_out,
  output logic internal_reset_out,
  // strobes
  output logic program_store_strobe_n_out,
  output logic ext_data_store_strobe_n_out,
  output logic ext_data_load_strobe_n_out
);
  import mso_pkg::*;

  // ==========================================
  // machine-cycle timing
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic cycle_end;
  assign cycle_end = (phase_r == `MSO_PHASE_LAST);
  assign phase_nxt = cycle_end ? 3'h0 : phase_r + 3'h1;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ==========================================
  // reset pin qualifier
  // sampled once per machine cycle so glitches shorter than a cycle are ignored
  logic [1:0] rst_cnt_r;
  logic [1:0] rst_cnt_nxt;
  logic int_rst_r;
  assign rst_cnt_nxt = !reset_pin_in ? 2'h0 :
                       (rst_cnt_r == `MSO_RST_SAMPLES) ? rst_cnt_r : rst_cnt_r + 2'h1;

  logic rst_hit;
  assign rst_hit = (rst_cnt_nxt == `MSO_RST_SAMPLES);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rst_cnt_r <= 2'h0;
    end else if (cycle_end) begin
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // held up through the first machine cycle so the core never starts mid-cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      int_rst_r <= 1'b1;
    end else if (cycle_end) begin
      int_rst_r <= rst_hit;
    end
  end

  // ==========================================
  // code fetch routing
  logic fetch_ext;
  assign fetch_ext = !external_fetch_select_n_in
                     || (fetch_addr_in > `MSO_CODE_ONCHIP_TOP);

  // ==========================================
  // external data access sequencer
  // an access owns one whole machine cycle; both strobe slots of it are dropped
  mso_xstate_e xstate_r;
  mso_xstate_e xstate_nxt;
  logic xwrite_r;
  logic [15:0] xaddr_r;
  logic xstart;
  assign xstart = xdata_req_in.valid && (xstate_r == MSO_X_IDLE) && cycle_end;

  always_comb begin
    xstate_nxt = xstate_r;
    case (xstate_r)
      MSO_X_IDLE: begin
        if (xstart) begin
          xstate_nxt = MSO_X_BUSY;
        end
      end
      MSO_X_BUSY: begin
        if (cycle_end) begin
          xstate_nxt = MSO_X_IDLE;
        end
      end
      default: xstate_nxt = MSO_X_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xstate_r <= MSO_X_IDLE;
    end else if (int_rst_r) begin
      xstate_r <= MSO_X_IDLE;
    end else begin
      xstate_r <= xstate_nxt;
    end
  end

  // direction and address latched at take, held for the whole access
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      xwrite_r <= 1'b0;
      xaddr_r <= 16'h0000;
    end else if (xstart && !int_rst_r) begin
      xwrite_r <= xdata_req_in.write;
      xaddr_r <= xdata_req_in.addr;
    end
  end

  // ==========================================
  // strobes
  logic xbusy;
  logic pstrobe_slot;
  logic pstrobe_n_nxt;
  logic dstrobe_on;
  assign xbusy = (xstate_r == MSO_X_BUSY);
  assign pstrobe_slot = (phase_r == `MSO_STROBE_PH_A) || (phase_r == `MSO_STROBE_PH_B);
  assign pstrobe_n_nxt = !(pstrobe_slot && fetch_valid_in && fetch_ext
                           && !xbusy && !int_rst_r);
  assign dstrobe_on = xbusy && (phase_r >= `MSO_DATA_STROBE_PH) && !int_rst_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      program_store_strobe_n_out <= 1'b1;
    end else begin
      program_store_strobe_n_out <= pstrobe_n_nxt;
    end
  end

  // write and read strobes never fall together: xwrite_r picks exactly one
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ext_data_store_strobe_n_out <= 1'b1;
    end else begin
      ext_data_store_strobe_n_out <= !(dstrobe_on && xwrite_r);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ext_data_load_strobe_n_out <= 1'b1;
    end else begin
      ext_data_load_strobe_n_out <= !(dstrobe_on && !xwrite_r);
    end
  end

  // ==========================================
  // internal ram and address decode
  logic [7:0] ram_r [0:255];
  logic [7:0] sp_r;
  logic [7:0] sp_nxt;
  logic [7:0] flags_r;
  logic [7:0] acc_r;
  logic [7:0] aux_r;
  logic [1:0] bank;
  logic is_push;
  logic is_pop;
  logic sfr_hit;
  logic [7:0] eff_addr;
  logic ram_sel;
  logic ram_wr;
  logic sfr_wr;
  logic [7:0] bit_byte;
  logic [7:0] bit_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] rdata_nxt;

  assign bank = flags_r[`MSO_FLAGS_BANK_HI:`MSO_FLAGS_BANK_LO];
  assign is_push = mem_req_in.valid && (mem_req_in.op == MSO_OP_PUSH);
  assign is_pop = mem_req_in.valid && (mem_req_in.op == MSO_OP_POP);
  assign sp_nxt = is_push ? sp_r + 8'h01 : is_pop ? sp_r - 8'h01 : sp_r;
  // bank registers are bank*8+index; bit area byte is 20H + bit[6:3]
  assign bit_byte = `MSO_RAM_BIT_BASE | {4'h0, bit_addr_in[6:3]};
  assign eff_addr = bank_work_in ? {3'h0, bank, bank_reg_in} :
                    bit_access_in ? bit_byte :
                    is_push ? sp_nxt :
                    is_pop ? sp_r : mem_req_in.addr;
  // direct upper-half access never reaches ram
  assign sfr_hit = !bank_work_in && !bit_access_in && !is_push && !is_pop
                   && (mem_req_in.mode == MSO_DIRECT) && eff_addr[`MSO_UPPER_BIT];
  assign ram_sel = mem_req_in.valid && !sfr_hit;
  assign ram_wr = ram_sel && ((mem_req_in.op == MSO_OP_WRITE) || is_push);
  assign sfr_wr = mem_req_in.valid && sfr_hit && (mem_req_in.op == MSO_OP_WRITE);
  // read-modify-write of one bit inside the bit area
  always_comb begin
    bit_wdata = ram_r[bit_byte];
    bit_wdata[bit_addr_in[2:0]] = mem_req_in.wdata[0];
  end

  // unoccupied addresses read as fill, writes dropped
  assign sfr_rdata = (eff_addr == `MSO_SFR_SP) ? sp_r :
                     (eff_addr == `MSO_SFR_FLAGS) ? flags_r :
                     (eff_addr == `MSO_SFR_ACC) ? acc_r :
                     (eff_addr == `MSO_SFR_AUX) ? aux_r : `MSO_RD_FILL;
  assign rdata_nxt = sfr_hit ? sfr_rdata : ram_r[eff_addr];

  // array left without reset: ram content is undefined at power-up
  always_ff @(posedge clk_sys_in) begin
    if (ram_wr && !int_rst_r) begin
      ram_r[eff_addr] <= bit_access_in ? bit_wdata : mem_req_in.wdata;
    end
  end

  logic sp_wr;
  logic flags_wr;
  logic acc_wr;
  logic aux_wr;
  assign sp_wr = sfr_wr && (eff_addr == `MSO_SFR_SP);
  assign flags_wr = sfr_wr && (eff_addr == `MSO_SFR_FLAGS);
  assign acc_wr = sfr_wr && (eff_addr == `MSO_SFR_ACC);
  assign aux_wr = sfr_wr && (eff_addr == `MSO_SFR_AUX);

  // a push or pop never meets a direct write here: sfr_hit excludes stack ops
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sp_r <= `MSO_SP_RST;
    end else if (int_rst_r) begin
      sp_r <= `MSO_SP_RST;
    end else if (sp_wr) begin
      sp_r <= mem_req_in.wdata;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= `MSO_BYTE_ZERO;
    end else if (int_rst_r) begin
      flags_r <= `MSO_BYTE_ZERO;
    end else if (flags_wr) begin
      flags_r <= mem_req_in.wdata;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= `MSO_BYTE_ZERO;
    end else if (int_rst_r) begin
      acc_r <= `MSO_BYTE_ZERO;
    end else if (acc_wr) begin
      acc_r <= mem_req_in.wdata;
    end
  end

  // an arithmetic result wins over a software write in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aux_r <= `MSO_BYTE_ZERO;
    end else if (int_rst_r) begin
      aux_r <= `MSO_BYTE_ZERO;
    end else if (mul_op_in == MSO_MUL_LOAD) begin
      aux_r <= mul_result_in;
    end else if (aux_wr) begin
      aux_r <= mem_req_in.wdata;
    end
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_rdata_out <= `MSO_BYTE_ZERO;
      bit_rdata_out <= 1'b0;
    end else begin
      mem_rdata_out <= rdata_nxt;
      bit_rdata_out <= ram_r[bit_byte][bit_addr_in[2:0]];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_external_out <= 1'b0;
      code_addr_out <= 16'h0000;
    end else begin
      fetch_external_out <= fetch_ext;
      code_addr_out <= fetch_addr_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      machine_cycle_out <= 1'b0;
      internal_reset_out <= 1'b1;
    end else begin
      machine_cycle_out <= cycle_end;
      internal_reset_out <= int_rst_r;
    end
  end

  assign stack_pointer_out = sp_r;
  assign bank_select_out = bank;
  assign multiply_divide_aux_out = aux_r;
  assign xdata_addr_out = xaddr_r;
endmodule // mso_top
`default_nettype wire

// file: mso_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mso_monitor
  import mso_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // watched inputs
  input wire logic fetch_valid_in,
  input wire logic external_fetch_select_n_in,
  input wire logic [15:0] fetch_addr_in,
  input wire mso_pkg::mso_req_s mem_req_in,
  input wire mso_pkg::mso_mul_e mul_op_in,
  input wire logic [7:0] mul_result_in,
  // watched outputs
  input wire logic [7:0] mem_rdata_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic [1:0] bank_select_out,
  input wire logic [7:0] multiply_divide_aux_out,
  input wire logic machine_cycle_out,
  input wire logic internal_reset_out,
  input wire logic program_store_strobe_n_out,
  input wire logic ext_data_store_strobe_n_out,
  input wire logic ext_data_load_strobe_n_out
);
  // ====
  // properties
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic take_w = mem_req_in.valid && !internal_reset_out;
  wire logic xfer_w = !ext_data_store_strobe_n_out || !ext_data_load_strobe_n_out;
  a_strobe_cause: assert property ($fell(program_store_strobe_n_out) |->
    $past(fetch_valid_in) && ($past(fetch_addr_in) > 16'h1fff || !$past(external_fetch_select_n_in)))
    else $error("code strobe without external fetch");
  a_strobe_width: assert property (!program_store_strobe_n_out |=> program_store_strobe_n_out)
    else $error("code strobe too long");
  a_data_quiet: assert property (xfer_w |-> program_store_strobe_n_out &&
    (ext_data_store_strobe_n_out || ext_data_load_strobe_n_out)) else $error("strobe overlap");
  a_load_len: assert property ($fell(ext_data_load_strobe_n_out) |->
    !ext_data_load_strobe_n_out [*3] ##1 ext_data_load_strobe_n_out) else $error("load strobe width");
  a_mc_period: assert property (machine_cycle_out |=> !machine_cycle_out [*5] ##1 machine_cycle_out)
    else $error("machine cycle period");
  a_sp_hold: assert property (internal_reset_out |=> stack_pointer_out == 8'h07 && bank_select_out == 2'h0)
    else $error("reset state lost");
  a_push_pre: assert property (take_w && mem_req_in.op == MSO_OP_PUSH |=>
    stack_pointer_out == $past(stack_pointer_out) + 8'h01) else $error("push increment");
  a_aux_load: assert property (mul_op_in == MSO_MUL_LOAD && !internal_reset_out |=>
    multiply_divide_aux_out == $past(mul_result_in)) else $error("aux load");
  a_sfr_sp_read: assert property (take_w && mem_req_in.op == MSO_OP_READ && mem_req_in.mode == MSO_DIRECT &&
    mem_req_in.addr == 8'h81 |=> mem_rdata_out == $past(stack_pointer_out)) else $error("stack read");
  c_push: cover property (take_w && mem_req_in.op == MSO_OP_PUSH);
  c_xfer: cover property ($fell(ext_data_store_strobe_n_out));
  c_pin_reset: cover property ($rose(internal_reset_out));
endmodule // mso_monitor
bind mso_top mso_monitor u_mso_monitor (.*);
`default_nettype wire

// file: mso_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mso_ext_mem (
  // strobes from the device
  input wire logic clk_sys_in,
  input wire logic code_n_in,
  input wire logic store_n_in,
  input wire logic load_n_in,
  input wire logic [15:0] addr_in,
  // activity seen
  output var int code_rd_out,
  output var int data_wr_out,
  output var int data_rd_out,
  output logic [15:0] addr_out
);
  logic [2:0] prev_r = 3'h7;
  initial {code_rd_out, data_wr_out, data_rd_out} = '0;
  // ====
  // a strobe counts once, on its falling edge
  always @(posedge clk_sys_in) begin
    prev_r <= {load_n_in, store_n_in, code_n_in};
    if (prev_r[0] && !code_n_in) code_rd_out <= code_rd_out + 1;
    if (prev_r[1] && !store_n_in) data_wr_out <= data_wr_out + 1;
    if (prev_r[2] && !load_n_in) data_rd_out <= data_rd_out + 1;
    if (!store_n_in || !load_n_in) addr_out <= addr_in;
  end
endmodule // mso_ext_mem
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import mso_pkg::*;
  // ====
  // stimulus, outputs and model
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic rpin = 1'h0;
  logic sel_n = 1'h1;
  logic fv = 1'h0;
  logic bacc = 1'h0;
  logic bwk = 1'h0;
  logic [15:0] fa = 16'h0000;
  logic [6:0] ba = 7'h00;
  logic [2:0] br = 3'h0;
  logic [7:0] mres = 8'h00;
  logic [31:0] seed = 32'h7d8c_e26a;
  mso_req_s req = '0;
  mso_mul_e mop = MSO_MUL_NONE;
  mso_xreq_s xreq = '0;
  logic [7:0] rd, sp, aux;
  logic [1:0] bank;
  logic [15:0] ca, xa, la;
  logic fext, mc, irst, psn, wsn, rsn, brd;
  int mismatches = 0;
  int compares = 0;
  int mcs = 0;
  int ram [256];
  int cr, dw, dr, c0, c1, c2, c3, i, msp;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (mc === 1'h1) mcs++;
  mso_top u_mso_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reset_pin_in(rpin),
    .external_fetch_select_n_in(sel_n), .fetch_valid_in(fv), .fetch_addr_in(fa), .mem_req_in(req),
    .bit_access_in(bacc), .bit_addr_in(ba), .bank_work_in(bwk), .bank_reg_in(br), .mul_op_in(mop),
    .mul_result_in(mres), .xdata_req_in(xreq), .mem_rdata_out(rd), .bit_rdata_out(brd),
    .stack_pointer_out(sp), .bank_select_out(bank), .multiply_divide_aux_out(aux), .fetch_external_out(fext),
    .code_addr_out(ca), .xdata_addr_out(xa), .machine_cycle_out(mc), .internal_reset_out(irst),
    .program_store_strobe_n_out(psn), .ext_data_store_strobe_n_out(wsn), .ext_data_load_strobe_n_out(rsn));
  mso_ext_mem u_mso_ext_mem (.clk_sys_in(clk_sys_in), .code_n_in(psn), .store_n_in(wsn), .load_n_in(rsn),
    .addr_in(xa), .code_rd_out(cr), .data_wr_out(dw), .data_rd_out(dr), .addr_out(la));
  // ====
  // tasks
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // w selects machine cycle pulse, else internal reset
  task automatic bw(input logic w, input logic v);
    for (i = 0; i < 99 && (w ? mc : irst) !== v; i++) @(negedge clk_sys_in);
    `CHK((w ? mc : irst), v)
    if ((w ? mc : irst) !== v) finish_test();
  endtask
  task automatic mcyc(input int n);
    repeat (n) begin
      @(negedge clk_sys_in);
      bw(1'h1, 1'h1);
    end
  endtask
  task automatic acc(input mso_op_e op, input mso_mode_e md, input logic [7:0] a, input logic [7:0] wd);
    req = '{1'h1, op, md, a, wd};
    @(negedge clk_sys_in);
  endtask
  task automatic wr(input mso_mode_e md, input logic [7:0] a, input logic [7:0] wd);
    acc(MSO_OP_WRITE, md, a, wd);
    if (md == MSO_INDIRECT || !a[7]) ram[a] = wd;
  endtask
  task automatic rchk(input mso_mode_e md, input logic [7:0] a, input logic [7:0] e);
    acc(MSO_OP_READ, md, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic xfer(input logic w, input logic [15:0] a);
    @(negedge clk_sys_in);
    xreq = '{1'h1, w, a};
    for (i = 0; i < 30 && xa !== a; i++) @(negedge clk_sys_in);
    `CHK(xa, a)
    if (xa !== a) finish_test();
    xreq.valid = 1'h0;
  endtask
  // ====
  // main sequence
  initial begin
    repeat (8) @(negedge clk_sys_in);
    rst_in = 1'h0;
    bw(1'h0, 1'h0);
    msp = 7;
    `CHK(sp, 8'h07)
    `CHK(aux, 8'h00)
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      msp++;
      ram[msp] = seed[7:0];
      acc(MSO_OP_PUSH, MSO_INDIRECT, 8'h00, seed[7:0]);
    end
    `CHK(sp, msp[7:0])
    rchk(MSO_INDIRECT, 8'h08, ram[8][7:0]);
    seed = lfsr(seed);
    wr(MSO_DIRECT, 8'h45, seed[7:0]);
    wr(MSO_INDIRECT, 8'hc3, seed[15:8]);
    wr(MSO_DIRECT, 8'hc3, 8'h00);
    wr(MSO_DIRECT, 8'h21, 8'h00);
    wr(MSO_DIRECT, 8'hd0, 8'h10);
    bwk = 1'h1;
    br = 3'h3;
    wr(MSO_DIRECT, 8'h13, seed[23:16]);
    bwk = 1'h0;
    bacc = 1'h1;
    ba = 7'h0b;
    acc(MSO_OP_WRITE, MSO_DIRECT, 8'h00, 8'h01);
    bacc = 1'h0;
    rchk(MSO_DIRECT, 8'h45, ram[8'h45][7:0]);
    rchk(MSO_INDIRECT, 8'hc3, ram[8'hc3][7:0]);
    rchk(MSO_DIRECT, 8'hc3, 8'hff);
    rchk(MSO_DIRECT, 8'h81, msp[7:0]);
    rchk(MSO_INDIRECT, 8'h13, ram[8'h13][7:0]);
    rchk(MSO_DIRECT, 8'h21, 8'h08);
    req.valid = 1'h0;
    @(negedge clk_sys_in);
    `CHK(brd, 1'h1)
    `CHK(bank, 2'h2)
    mop = MSO_MUL_LOAD;
    mres = seed[31:24];
    @(negedge clk_sys_in);
    mop = MSO_MUL_NONE;
    `CHK(aux, mres)
    fv = 1'h1;
    for (int k = 0; k < 3; k++) begin
      sel_n = (k != 2);
      fa = (k == 1) ? 16'h4000 : 16'h0100;
      mcyc(1);
      c0 = cr;
      mcyc(4);
      `CHK(cr - c0, (k == 0) ? 0 : 8)
    end
    `CHK(fext, 1'h1)
    `CHK(ca, fa)
    mcyc(1);
    c0 = cr;
    c1 = dw;
    c2 = dr;
    c3 = mcs;
    xfer(1'h1, 16'h8a5c);
    xfer(1'h0, 16'h1234);
    mcyc(2);
    `CHK(cr - c0, 2 * (mcs - c3) - 4)
    `CHK(dw - c1, 1)
    `CHK(dr - c2, 1)
    `CHK(la, 16'h1234)
    rpin = 1'h1;
    mcyc(3);
    `CHK(irst, 1'h1)
    `CHK(sp, 8'h07)
    rpin = 1'h0;
    bw(1'h0, 1'h0);
    `CHK(bank, 2'h0)
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
